// file: rhp_port.sv
// Four-wire serial slave port with write FIFO, read snapshot and seconds carry hold
`timescale 1ns/10ps
module rhp_port (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic ce_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic [rhp_pkg::SNAP_W-1:0] rd_regs_i,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [rhp_pkg::ADDR_W-1:0] wr_addr_o,
    output logic [rhp_pkg::DATA_W-1:0] wr_data_o,
    output logic wr_overflow_o,
    output logic session_o,
    input wire logic sec_tick_i,
    output logic sec_carry_o
);

    // Clock phase chosen at enable rise
    logic phase_hi_reg;
    logic samp_clk;
    logic link_rst_n;
    logic arm_reg;
    logic ce_rst_n;

    rhp_pkg::rhp_link_type link_reg;
    rhp_pkg::rhp_link_type link_next;
    rhp_pkg::rhp_evt_type evt_reg;
    rhp_pkg::rhp_evt_type evt_next;
    rhp_pkg::rhp_out_type out_reg;
    rhp_pkg::rhp_out_type out_next;
    rhp_pkg::rhp_sys_type sys_reg;
    rhp_pkg::rhp_sys_type sys_next;

    logic [7:0] byte_in;
    logic byte_done;
    logic [7:0] rd_byte;
    logic ce_sync;
    logic tgl_sync;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    rhp_pkg::rhp_wr_type fifo_out_data;

    // Serial clock level latched by the enable rise
    always_ff @(posedge ce_i or negedge resetn_i)
    begin
        if (!resetn_i)
            phase_hi_reg <= 1'b0;
        else
            phase_hi_reg <= sclk_i;
    end

    // Sampling edge is falling for a low start, rising for a high start
    assign samp_clk = ~(sclk_i ^ phase_hi_reg);

    // Enable low clears the arming flag and the link logic
    assign ce_rst_n = resetn_i & ce_i;

    // A mode change moves the phase latch at enable rise and makes a false sampling edge;
    // the link stays cleared until the first output edge, which always precedes the first sample
    always_ff @(negedge samp_clk or negedge ce_rst_n)
    begin
        if (!ce_rst_n)
            arm_reg <= 1'b0;
        else
            arm_reg <= 1'b1;
    end

    // Enable low holds the link logic cleared, dropping any partial byte
    assign link_rst_n = ce_rst_n & arm_reg;

    // Incoming byte assembled most significant bit first
    assign byte_in = {link_reg.shift, si_i};
    assign byte_done = (link_reg.cnt == rhp_pkg::BIT_LAST);

    // Command decode and address walk on the sampling edge
    always_comb
    begin
        link_next = link_reg;
        evt_next = evt_reg;
        link_next.shift = byte_in[6:0];
        link_next.cnt = link_reg.cnt + 3'h1;
        if (byte_done)
        begin
            case (link_reg.phase)
                rhp_pkg::PH_CMD:
                begin
                    link_next.addr = byte_in[7:4];
                    link_next.fmt = byte_in[3:0];
                    case (byte_in[3:0])
                        rhp_pkg::FMT_WR_SINGLE,
                        rhp_pkg::FMT_WR_BURST:
                            link_next.phase = rhp_pkg::PH_WDATA;
                        rhp_pkg::FMT_RD_SINGLE,
                        rhp_pkg::FMT_RD_BURST:
                            link_next.phase = rhp_pkg::PH_RDATA;
                        default:
                            link_next.phase = rhp_pkg::PH_CMD;
                    endcase
                end
                rhp_pkg::PH_WDATA:
                begin
                    evt_next.word.addr = link_reg.addr;
                    evt_next.word.data = byte_in;
                    evt_next.tgl = ~evt_reg.tgl;
                    if (link_reg.fmt == rhp_pkg::FMT_WR_BURST)
                        link_next.addr = link_reg.addr + rhp_pkg::ADDR_STEP;
                    else
                        link_next.phase = rhp_pkg::PH_CMD;
                end
                rhp_pkg::PH_RDATA:
                begin
                    if (link_reg.fmt == rhp_pkg::FMT_RD_BURST)
                        link_next.addr = link_reg.addr + rhp_pkg::ADDR_STEP;
                    else
                        link_next.phase = rhp_pkg::PH_CMD;
                end
                default:
                    link_next.phase = rhp_pkg::PH_CMD;
            endcase
        end
    end

    // Session state restarts with every enable rise
    always_ff @(posedge samp_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            link_reg <= rhp_pkg::LINK_RESET;
        else
            link_reg <= link_next;
    end

    // Write event survives the enable fall so the last byte still crosses
    always_ff @(posedge samp_clk or negedge resetn_i)
    begin
        if (!resetn_i)
            evt_reg <= rhp_pkg::EVT_RESET;
        else
            evt_reg <= evt_next;
    end

    // Byte of the frozen snapshot at the current address
    assign rd_byte = sys_reg.snap[link_reg.addr * rhp_pkg::DATA_W +: rhp_pkg::DATA_W];

    // Output bit on the opposite edge, most significant bit first
    always_comb
    begin
        out_next.oe = (link_reg.phase == rhp_pkg::PH_RDATA);
        out_next.so = rd_byte[3'h7 - link_reg.cnt];
    end

    // Output driven only during read data; released at enable fall
    always_ff @(negedge samp_clk or negedge link_rst_n)
    begin
        if (!link_rst_n)
            out_reg <= rhp_pkg::OUT_RESET;
        else
            out_reg <= out_next;
    end

    assign so_o = out_reg.so;
    assign so_oe_o = out_reg.oe;

    // Enable level and write toggle brought into the system clock
    rhp_sync #(
        .W(2)
    ) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .d_i({ce_i, evt_reg.tgl}),
        .q_o({ce_sync, tgl_sync})
    );

    // New write toggle pushes the held word
    assign fifo_in_valid = (tgl_sync != sys_reg.tgl_seen);

    rhp_fifo #(
        .WIDTH(rhp_pkg::ADDR_W + rhp_pkg::DATA_W),
        .DEPTH(rhp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(evt_reg.word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // Output stage refills when empty or when the consumer takes the word
    assign fifo_out_ready = !sys_reg.wr_valid || wr_ready_i;

    // System side: write delivery, read snapshot and carry hold
    always_comb
    begin
        sys_next = sys_reg;
        sys_next.session = ce_sync;
        sys_next.carry = 1'b0;
        sys_next.tgl_seen = tgl_sync;
        if (fifo_in_valid && !fifo_in_ready)
            sys_next.overflow = 1'b1;
        if (fifo_out_ready)
        begin
            sys_next.wr_valid = fifo_out_valid;
            sys_next.wr = fifo_out_data;
        end
        // Snapshot tracks the registers only between sessions
        if (!ce_sync)
            sys_next.snap = rd_regs_i;
        if (!ce_sync)
        begin
            sys_next.carry = sec_tick_i || sys_reg.pend;
            sys_next.pend = 1'b0;
        end
        else if (sec_tick_i)
        begin
            if (sys_reg.pend)
                sys_next.carry = 1'b1;
            sys_next.pend = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sys_reg <= rhp_pkg::SYS_RESET;
        else
            sys_reg <= sys_next;
    end

    assign wr_valid_o = sys_reg.wr_valid;
    assign wr_addr_o = sys_reg.wr.addr;
    assign wr_data_o = sys_reg.wr.data;
    assign wr_overflow_o = sys_reg.overflow;
    assign session_o = sys_reg.session;
    assign sec_carry_o = sys_reg.carry;

endmodule

// file: rhp_pkg.sv
// Constants, types and reset values shared by the serial host port
package rhp_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int SNAP_W = NUM_REGS * DATA_W;

    // Access format codes
    localparam logic [3:0] FMT_WR_SINGLE = 4'h8;
    localparam logic [3:0] FMT_WR_BURST = 4'h0;
    localparam logic [3:0] FMT_RD_SINGLE = 4'hC;
    localparam logic [3:0] FMT_RD_BURST = 4'h4;

    // Bit counter within a byte and burst address step
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] ADDR_STEP = 4'h1;

    typedef enum logic [2:0]
    {
        PH_CMD = 3'b001,
        PH_WDATA = 3'b010,
        PH_RDATA = 3'b100
    } rhp_phase_type;

    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } rhp_wr_type;

    // Link side command state, cleared at every session start
    typedef struct packed
    {
        rhp_phase_type phase;
        logic [2:0] cnt;
        logic [6:0] shift;
        logic [ADDR_W-1:0] addr;
        logic [3:0] fmt;
    } rhp_link_type;

    // Write event handed to the system clock, kept across sessions
    typedef struct packed
    {
        rhp_wr_type word;
        logic tgl;
    } rhp_evt_type;

    typedef struct packed
    {
        logic so;
        logic oe;
    } rhp_out_type;

    typedef struct packed
    {
        logic tgl_seen;
        logic pend;
        logic carry;
        logic wr_valid;
        rhp_wr_type wr;
        logic overflow;
        logic session;
        logic [SNAP_W-1:0] snap;
    } rhp_sys_type;

    localparam rhp_link_type LINK_RESET = '{phase: PH_CMD, cnt: 3'h0, shift: 7'h00, addr: 4'h0, fmt: 4'h0};
    localparam rhp_evt_type EVT_RESET = '{word: '{addr: 4'h0, data: 8'h00}, tgl: 1'b0};
    localparam rhp_out_type OUT_RESET = '{so: 1'b0, oe: 1'b0};
    localparam rhp_sys_type SYS_RESET = '{tgl_seen: 1'b0, pend: 1'b0, carry: 1'b0, wr_valid: 1'b0,
                                          wr: '{addr: 4'h0, data: 8'h00}, overflow: 1'b0,
                                          session: 1'b0, snap: '0};

endpackage

// file: rhp_sync.sv
// Two-stage synchroniser for levels arriving from another clock domain
`timescale 1ns/10ps
module rhp_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed
    {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } rhp_sync_type;

    rhp_sync_type st_reg;
    rhp_sync_type st_next;

    // First stage feeds only the second
    always_comb
    begin
        st_next.meta = d_i;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign q_o = st_reg.stable;

endmodule

// file: rhp_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
module rhp_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int PW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [PW:0] count;
    } rhp_fifo_type;

    rhp_fifo_type st_reg;
    rhp_fifo_type st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Honest full and empty from the occupancy count
    assign in_ready_o = (st_reg.count != (PW+1)'(DEPTH));
    assign out_valid_o = (st_reg.count != '0);
    assign out_data_o = mem[st_reg.rptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Pointer and count update
    always_comb
    begin
        st_next = st_reg;
        if (push)
            st_next.wptr = (st_reg.wptr == PW'(DEPTH-1)) ? '0 : st_reg.wptr + PW'(1);
        if (pop)
            st_next.rptr = (st_reg.rptr == PW'(DEPTH-1)) ? '0 : st_reg.rptr + PW'(1);
        if (push && !pop)
            st_next.count = st_reg.count + (PW+1)'(1);
        else if (pop && !push)
            st_next.count = st_reg.count - (PW+1)'(1);
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    // Storage has no reset
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[st_reg.wptr] <= in_data_i;
    end

endmodule

// file: rhp_port_sva.sv
// Concurrent checks on the serial host port outputs
`timescale 1ns/10ps
module rhp_port_chk (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic so_oe_o,
    input wire logic wr_valid_o,
    input wire logic wr_ready_i,
    input wire logic [rhp_pkg::ADDR_W-1:0] wr_addr_o,
    input wire logic [rhp_pkg::DATA_W-1:0] wr_data_o,
    input wire logic wr_overflow_o,
    input wire logic session_o,
    input wire logic sec_tick_i,
    input wire logic sec_carry_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Serial output and write hand-off
    property p_oe_ce; !ce_i |-> !so_oe_o; endproperty
    a_oe_ce: assert property (p_oe_ce)
        else $error("so driven outside session");
    property p_wr_hold;
        wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write word changed before taken");
    property p_wr_drop; $fell(wr_valid_o) |-> $past(wr_ready_i); endproperty
    a_wr_drop: assert property (p_wr_drop)
        else $error("write word dropped untaken");
    property p_ovf; wr_overflow_o |=> wr_overflow_o; endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow flag cleared");
    // Session tracking and carry hold
    property p_ses_hi; ce_i [*4] |-> session_o; endproperty
    a_ses_hi: assert property (p_ses_hi)
        else $error("session not seen");
    property p_ses_lo; !ce_i [*4] |-> !session_o; endproperty
    a_ses_lo: assert property (p_ses_lo)
        else $error("session seen while idle");
    property p_car_one; sec_carry_o |=> !sec_carry_o; endproperty
    a_car_one: assert property (p_car_one)
        else $error("carry longer than one cycle");
    property p_car_held; sec_carry_o && session_o && $past(session_o) |-> $past(sec_tick_i); endproperty
    a_car_held: assert property (p_car_held)
        else $error("carry released in session");
    property p_car_free; sec_tick_i ##1 !session_o |-> sec_carry_o; endproperty
    a_car_free: assert property (p_car_free)
        else $error("carry missing while idle");
    c_wr: cover property (wr_valid_o && wr_ready_i);
    c_rd: cover property ($rose(so_oe_o));
    c_car: cover property ($fell(session_o) ##[1:4] sec_carry_o);
endmodule
bind rhp_port rhp_port_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .so_oe_o(so_oe_o),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .wr_overflow_o(wr_overflow_o), .session_o(session_o), .sec_tick_i(sec_tick_i), .sec_carry_o(sec_carry_o));

// file: rhp_host.sv
// Host processor model driving the four-wire serial link
`timescale 1ns/10ps
module rhp_host (
    output logic sclk_o,
    output logic ce_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    logic last;
    initial
    begin
        sclk_o = 1'b0;
        ce_o = 1'b0;
        si_o = 1'b0;
        last = 1'b0;
    end
    // Idle level picks the mode, then wait out any carry in progress
    task start(input logic idle);
        sclk_o = idle;
        #100 ce_o = 1'b1;
        #31000;
    endtask
    // Drop enable, invert the data line and keep the low gap
    task stop;
        #20 ce_o = 1'b0;
        si_o = ~si_o;
        #62000;
    endtask
    // Shift n bits from the top of tx; an undriven line reads back inverted
    task xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            si_o = tx[i];
            #8 sclk_o = ~sclk_o;
            #16 last = so_oe_i ? so_i : ~last;
            rx[i] = last;
            sclk_o = ~sclk_o;
            #8;
        end
    endtask
endmodule

// file: test_rtc_four_wire_host_port.sv
// Self-checking bench for the serial host port
`timescale 1ns/10ps
module test_rtc_four_wire_host_port;
    logic clk_i, resetn_i, wr_ready_i, sec_tick_i;
    logic [rhp_pkg::SNAP_W-1:0] rd_regs_i;
    logic sclk, ce, si, so, so_oe, wr_valid, ovf, session, carry;
    logic [3:0] wr_addr;
    logic [7:0] wr_data, rx;
    logic [11:0] wq[$];
    int bad_count, cmp_count, carry_cnt;
    rhp_port dut (.clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .ce_i(ce), .si_i(si), .so_o(so),
        .so_oe_o(so_oe), .rd_regs_i(rd_regs_i), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready_i),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_overflow_o(ovf), .session_o(session),
        .sec_tick_i(sec_tick_i), .sec_carry_o(carry));
    rhp_host host (.sclk_o(sclk), .ce_o(ce), .si_o(si), .so_i(so), .so_oe_i(so_oe));
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Collect taken writes and count carry pulses
    always @(posedge clk_i)
    begin
        if (wr_valid && wr_ready_i) wq.push_back({wr_addr, wr_data});
        if (carry) carry_cnt++;
    end
    function logic [7:0] regv(input int n);
        return 8'(n) ^ 8'hC3;
    endfunction
    task tick;
        @(posedge clk_i) #2;
    endtask
    task check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task expect_wr(input logic [3:0] a, input logic [7:0] d);
        for (int i = 0; i < 400 && wq.size() == 0; i++) tick;
        if (wq.size() == 0)
        begin
            bad_count++;
            end_of_test;
        end
        check(wq.pop_front(), {a, d});
    endtask
    task t_single_write;
        host.start(1'b0);
        host.xfer(8'hF8, 8, rx);
        host.xfer(8'h5A, 8, rx);
        host.xfer(8'h35, 8, rx);
        host.xfer(8'h78, 8, rx);
        host.xfer(8'hC3, 8, rx);
        host.stop();
        expect_wr(4'hF, 8'h5A);
        expect_wr(4'h7, 8'hC3);
        check(12'(wq.size()), 12'h000);
        $display("single write done");
    endtask
    task t_burst_write;
        host.start(1'b1);
        host.xfer(8'hE0, 8, rx);
        for (int i = 0; i < 3; i++) host.xfer(8'(8'h91 + i), 8, rx);
        host.xfer(8'hFF, 5, rx);
        host.stop();
        for (int i = 0; i < 3; i++) expect_wr(4'(4'hE + i), 8'(8'h91 + i));
        check(12'(wq.size()), 12'h000);
        $display("burst write done");
    endtask
    task t_read;
        host.start(1'b0);
        host.xfer(8'hEC, 8, rx);
        host.xfer(8'h00, 8, rx);
        check(12'(rx), 12'(regv(14)));
        tick;
        rd_regs_i[8*2 +: 8] = 8'h5D;
        host.xfer(8'h2C, 8, rx);
        host.xfer(8'h00, 8, rx);
        check(12'(rx), 12'(regv(2)));
        host.xfer(8'hFC, 8, rx);
        host.xfer(8'h00, 8, rx);
        check(12'(rx), 12'(regv(15)));
        host.xfer(8'hF8, 8, rx);
        host.xfer(8'h66, 8, rx);
        host.xfer(8'h3C, 8, rx);
        host.xfer(8'h00, 8, rx);
        check(12'(rx), 12'(regv(3)));
        host.stop();
        expect_wr(4'hF, 8'h66);
        host.start(1'b1);
        host.xfer(8'hF4, 8, rx);
        for (int i = 0; i < 3; i++)
        begin
            host.xfer(8'h00, 8, rx);
            check(12'(rx), 12'(regv((15 + i) % 16)));
        end
        host.xfer(8'h00, 8, rx);
        check(12'(rx), 12'h05D);
        host.stop();
        $display("read done");
    endtask
    task t_carry;
        int c0;
        c0 = carry_cnt;
        host.start(1'b0);
        tick;
        for (int i = 0; i < 2; i++)
        begin
            sec_tick_i = 1'b1;
            tick;
            sec_tick_i = 1'b0;
            repeat (4) tick;
        end
        check(12'(carry_cnt - c0), 12'h001);
        host.stop();
        check(12'(carry_cnt - c0), 12'h002);
        tick;
        sec_tick_i = 1'b1;
        tick;
        sec_tick_i = 1'b0;
        repeat (3) tick;
        check(12'(carry_cnt - c0), 12'h003);
        $display("carry done");
    endtask
    task t_fifo;
        wr_ready_i = 1'b0;
        host.start(1'b0);
        host.xfer(8'h00, 8, rx);
        for (int i = 0; i < 10; i++) host.xfer(8'(i + 8'h40), 8, rx);
        host.stop();
        check(12'(ovf), 12'h001);
        tick;
        wr_ready_i = 1'b1;
        for (int i = 0; i < 9; i++) expect_wr(4'(i), 8'(i + 8'h40));
        repeat (20) tick;
        check(12'(wr_valid), 12'h000);
        check(12'(wq.size()), 12'h000);
        $display("fifo done");
    endtask
    initial
    begin
        resetn_i = 1'b0;
        wr_ready_i = 1'b1;
        sec_tick_i = 1'b0;
        for (int n = 0; n < 16; n++) rd_regs_i[8*n +: 8] = regv(n);
        repeat (20) @(posedge clk_i);
        #2 resetn_i = 1'b1;
        repeat (3) tick;
        t_single_write;
        t_burst_write;
        t_read;
        t_carry;
        t_fifo;
        end_of_test;
    end
endmodule
